//--- dv/lts_card_model.sv
// card store model: takes characters, deletes oldest files on request
// assumes the bench loads fullness and usage between records
`timescale 1ns/1ns
module lts_card_model (
  input wire logic        mclk,          // clock
  input wire logic        rstn,          // reset, low
  input wire logic        card_valid,    // char offered
  input wire logic [7:0]  card_data,     // char
  output logic            card_ready,    // char taken
  input wire logic        delete_oldest, // delete request
  output logic            delete_done,   // delete finished
  output logic            card_full,     // no room
  output logic [23:0]     card_used_mb,  // stored MB
  input wire logic        stall,         // refuse characters
  input wire logic        load,          // take load values
  input wire logic        load_full,     // fullness to load
  input wire logic [23:0] load_used      // usage to load
);
  logic [7:0] got[$];
  logic [1:0] wait_cnt;
  // a delete frees 10 MB three cycles later
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      {card_ready, delete_done, card_full, card_used_mb, wait_cnt} <= '0;
    end else begin
      card_ready <= !stall && $urandom % 4 != 0;
      delete_done <= 1'b0;
      if (card_valid && card_ready) got.push_back(card_data);
      if (load) begin
        card_full <= load_full;
        card_used_mb <= load_used;
      end
      if (delete_oldest) wait_cnt <= 2'h3;
      else if (wait_cnt != 2'h0) wait_cnt <= wait_cnt - 2'h1;
      if (wait_cnt == 2'h1 && !delete_oldest) begin
        delete_done <= 1'b1;
        card_full <= 1'b0;
        card_used_mb <= card_used_mb > 24'hA ? card_used_mb - 24'hA : 24'h0;
      end
    end
  end
endmodule

//--- dv/lts_logger_assertions.sv
// concurrent checks on the logger ports
// assumes a store taking three cycles per delete
`timescale 1ns/1ns
module lts_chk #(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic        mclk,                  // clock
  input wire logic        rstn,                  // reset, low
  input wire logic        ctrl_valid,            // control
  input wire logic [7:0]  ctrl_state,            // state byte
  input wire logic        logging_on,            // state
  input wire logic        file_open,             // open pulse
  input wire logic        file_close,            // close pulse
  input wire logic        card_valid,            // char out
  input wire logic        delete_oldest,         // delete
  input wire logic        overwrite_oldest_mode, // mode
  input wire logic        card_full,             // full
  input wire logic [23:0] card_used_mb,          // used MB
  input wire logic [9:0]  split_size_limit,      // split MB
  input wire logic [23:0] stored_total_cap       // cap MB
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  logic [24:0] room;
  logic        need;
  assign room = {1'b0, card_used_mb} + 25'(split_size_limit);
  assign need = card_full || (stored_total_cap != 24'h0 && room >= 25'(stored_total_cap));
  sequence s_req; delete_oldest; endsequence
  sequence s_wait; (!delete_oldest && !file_open) [*2]; endsequence
  property p_on; ctrl_valid && ctrl_state == 8'h01 |=> logging_on; endproperty
  a_on: assert property (p_on) else $error("logging not on");
  property p_off; ctrl_valid && ctrl_state == 8'h00 |=> !logging_on; endproperty
  a_off: assert property (p_off) else $error("logging not off");
  // only an on or off control moves the state
  property p_hold; !(ctrl_valid && ctrl_state < 8'h02) && $past(rstn, 2) |=> $stable(logging_on);
  endproperty
  a_hold: assert property (p_hold) else $error("logging state moved");
  property p_drain; file_close |-> !card_valid; endproperty
  a_drain: assert property (p_drain) else $error("file closed with data queued");
  property p_reopen; file_close && !card_full |-> ##[1:200] file_open; endproperty
  a_reopen: assert property (p_reopen) else $error("no new file");
  property p_mode; delete_oldest |-> overwrite_oldest_mode; endproperty
  a_mode: assert property (p_mode) else $error("delete without mode");
  property p_cause; delete_oldest |-> need; endproperty
  a_cause: assert property (p_cause) else $error("delete without need");
  property p_wait; s_req |=> s_wait; endproperty
  a_wait: assert property (p_wait) else $error("delete not awaited");
endmodule
bind lts_logger lts_chk #(.FIFO_DEPTH(FIFO_DEPTH)) lts_chk_i (.*);

//--- dv/test_log_timestamp_and_file_split.sv
// self-checking bench for the log timestamp and file split block
// assumes the card store model
`timescale 1ns/1ns
module test_log_timestamp_and_file_split
  import lts_pkg::*;
;
  logic             mclk, rstn, default_log_state, overwrite_oldest_mode, ctrl_valid;
  logic             rtc_sec_tick, rec_valid, rec_ready, card_full, delete_done;
  logic             delete_oldest, file_open, file_close, logging_on, card_valid;
  logic             card_ready, stall, load, load_full;
  logic [2:0]       stamp_detail_level;
  logic [7:0]       clock_field_delimiter, millis_delimiter, calendar_delimiter;
  logic [7:0]       calendar_clock_delimiter, field_delimiter_code, ctrl_state, card_data;
  logic [14:0][7:0] logger_name_string;
  logic [9:0]       split_size_limit;
  logic [16:0]      split_period, split_offset, rtc_sec_of_day;
  logic [23:0]      stored_total_cap, card_used_mb, load_used;
  lts_rtc_t         rtc_now;
  lts_beat_t        rec_beat;
  logic [7:0]       exp[$];
  int               errors, n_checks, cyc, n_close, n_del;

  lts_logger lts_logger_i (.*);
  lts_card_model lts_card_model_i (.*);

  always #4 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    n_close += int'(file_close === 1'b1);
    n_del += int'(delete_oldest === 1'b1);
    if (cyc == 50000) begin
      errors++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d, errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] want);
    n_checks++;
    if (got !== want) begin
      errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, want);
    end
  endtask

  function automatic void put_d(input logic [7:0] c);
    if (c != 8'h00) exp.push_back(c);
  endfunction

  function automatic void put_f(input logic [15:0] v, input int n, input logic [7:0] d,
                                input bit on);
    if (!on) return;
    for (int i = n - 1; i >= 0; i--) exp.push_back(8'h30 + 8'(v[i*4 +: 4]));
    put_d(d);
  endfunction

  // zero or printable codes, never the field code
  function automatic logic [7:0] dl(input int i);
    if (i == 7) return 8'h00;
    return (i == 8 || $urandom % 2) ? 8'(32 + $urandom % 27) : 8'h00;
  endfunction

  task automatic send_rec(input int n, input bit keep, input bit head);
    logic [7:0] c;
    bit         fe;
    int         l;
    l = int'(stamp_detail_level);
    for (int i = 0; i < 15; i++) if (keep && head) put_d(logger_name_string[i]);
    if (keep && head) exp.push_back(8'h0A);
    put_f(rtc_now.year, 4, calendar_delimiter, keep && l >= 6);
    put_f(16'(rtc_now.month), 2, calendar_delimiter, keep && l >= 5);
    put_f(16'(rtc_now.day), 2, calendar_clock_delimiter, keep && l >= 4);
    put_f(16'(rtc_now.hour), 2, clock_field_delimiter, keep && l >= 3);
    put_f(16'(rtc_now.minute), 2, clock_field_delimiter, keep && l >= 2);
    put_f(16'(rtc_now.second), 2, millis_delimiter, keep && l >= 1);
    put_f(16'(rtc_now.milli), 3, field_delimiter_code, keep);
    for (int i = 0; i < n; i++) begin
      c = 8'(65 + $urandom % 26);
      fe = i < n - 1 && $urandom % 3 == 0;
      @(negedge mclk);
      rec_beat = '{c, fe, i == n - 1};
      rec_valid = 1'b1;
      while (rec_ready !== 1'b1) @(negedge mclk);
      if (keep) exp.push_back(c);
      if (keep && fe) exp.push_back(field_delimiter_code);
    end
    if (keep) exp.push_back(8'h0A);
    @(negedge mclk);
    rec_valid = 1'b0;
  endtask

  task automatic check_out(input string t);
    logic [7:0] got[$];
    repeat (3000) if (lts_card_model_i.got.size() < exp.size()) @(negedge mclk);
    repeat (40) @(negedge mclk);
    got = lts_card_model_i.got;
    check(32'(got.size()), 32'(exp.size()));
    foreach (exp[i]) if (i < got.size()) check(got[i], exp[i]);
    lts_card_model_i.got.delete();
    exp.delete();
    $display("test %s done", t);
  endtask

  task automatic ctl(input logic [7:0] v);
    @(negedge mclk);
    ctrl_valid = 1'b1;
    ctrl_state = v;
    @(negedge mclk);
    ctrl_valid = 1'b0;
  endtask

  task automatic tick(input int s);
    @(negedge mclk);
    rtc_sec_of_day = 17'(s);
    rtc_sec_tick = 1'b1;
    @(negedge mclk);
    rtc_sec_tick = 1'b0;
  endtask

  initial begin
    int k;
    {mclk, rstn, ctrl_valid, rtc_sec_tick, rec_valid, stall, load, load_full} = '0;
    {default_log_state, overwrite_oldest_mode, ctrl_state, load_used, rtc_sec_of_day} = '0;
    {clock_field_delimiter, millis_delimiter, calendar_delimiter} = '0;
    {calendar_clock_delimiter, split_period, split_offset, stored_total_cap} = '0;
    {stamp_detail_level, rec_beat} = '0;
    field_delimiter_code = 8'h3B;
    split_size_limit = 10'h014;
    rtc_now = '{16'h2016, 8'h06, 8'h05, 8'h12, 8'h30, 8'h45, 12'h525};
    for (int i = 0; i < 15; i++) logger_name_string[i] = 8'(97 + i);
    k = $urandom(32'h5B13326B);
    repeat (8) @(negedge mclk);
    rstn = 1'b1;
    repeat (2) @(negedge mclk);
    check(logging_on, 0);
    send_rec(3, 0, 0);
    check_out("quiet");
    ctl(8'h01);
    check(logging_on, 1);
    ctl(8'h55);
    check(logging_on, 1);
    for (int i = 0; i < 9; i++) begin
      stamp_detail_level = 3'(i % 7);
      clock_field_delimiter = dl(i);
      millis_delimiter = dl(i);
      calendar_delimiter = dl(i);
      calendar_clock_delimiter = dl(i);
      rtc_now.milli[3:0] = 4'($urandom % 10);
      send_rec(2 + i, 1, i == 0);
      check_out("stamp");
    end
    // long stall makes the buffer refuse
    fork
      send_rec(14, 1, 0);
      begin
        stall = 1'b1;
        repeat (60) @(negedge mclk);
        check(rec_ready, 0);
        check(card_valid, 1);
        stall = 1'b0;
      end
    join
    check_out("stall");
    split_period = 17'h0003C;
    for (int j = 0; j < 4; j++) begin
      k = n_close;
      split_offset = j < 2 ? 17'h0 : 17'h0001E;
      tick(j == 0 ? 61 : j == 1 ? 120 : j == 2 ? 20 : 90);
      send_rec(2, 1, j % 2);
      check_out("split");
      check(n_close - k, j % 2);
    end
    // cap of 40 MB is twice the split size
    overwrite_oldest_mode = 1'b1;
    for (int j = 0; j < 3; j++) begin
      k = n_del;
      stored_total_cap = j == 1 ? 24'h28 : 24'h0;
      load_full = j == 0;
      load_used = 24'h23;
      load = 1'b1;
      @(negedge mclk);
      load = 1'b0;
      tick(150 + 60 * j);
      send_rec(2, 1, 1);
      check_out("room");
      check(n_del - k, j == 2 ? 0 : j + 1);
    end
    ctl(8'h00);
    check(logging_on, 0);
    send_rec(3, 0, 0);
    check_out("off");
    final_report();
  end
endmodule

//--- logic/lts_defs.svh
// constants for the log timestamp and file split block
// assumes an 8-bit character stream towards the card store
`ifndef LTS_DEFS_SVH
`define LTS_DEFS_SVH

`define LTS_CHAR_W        8
`define LTS_FIFO_DEPTH    8
`define LTS_NAME_LEN      15
`define LTS_STAMP_MAX     23
`define LTS_DIGITS        17
`define LTS_LEVEL_MAX     3'h6
`define LTS_ASCII_ZERO    8'h30
`define LTS_ASCII_NL      8'h0A
`define LTS_CTRL_ON       8'h01
`define LTS_CTRL_OFF      8'h00
`define LTS_MB_SHIFT      20
`define LTS_SPLIT_MB_W    10
`define LTS_SOD_W         17
`define LTS_CAP_MB_W      24
`define LTS_BYTES_W       32

`endif

//--- logic/lts_fifo.sv
// character FIFO between the record formatter and the card store
// assumes a power-of-two depth; output stage is registered
`timescale 1ns/1ns
module lts_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic             mclk,      // clock
  input  wire logic             rstn,      // async reset, active low
  input  wire logic             in_valid,  // write request
  input  wire logic [W-1:0]     in_data,   // write data
  output logic                  in_ready,  // room for one more word
  output logic                  out_valid, // read data held
  output logic [W-1:0]          out_data,  // read data
  input  wire logic             out_ready, // reader takes the word
  output logic [$clog2(D):0]    level,     // words in storage
  output logic                  idle       // storage and output empty
);
  localparam int AW = $clog2(D);

  generate
    if (D < 4 || (D & (D - 1)) != 0) begin : g_bad_depth
      $error("lts_fifo depth must be a power of two of at least 4");
    end
  endgenerate

  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0]   count, next_count;
  logic          next_out_valid;
  logic [W-1:0]  next_out_data;
  logic          push, load;

  always_comb begin
    in_ready       = (count < (AW+1)'(D));
    push           = in_valid && in_ready;
    load           = (count != '0) && (!out_valid || out_ready);
    next_wr_ptr    = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr    = load ? rd_ptr + 1'b1 : rd_ptr;
    next_count     = count + (AW+1)'(push) - (AW+1)'(load);
    next_out_valid = load ? 1'b1 : (out_ready ? 1'b0 : out_valid);
    next_out_data  = load ? mem[rd_ptr] : out_data;
    level          = count;
    idle           = (count == '0) && !out_valid;
  end

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end else begin
      wr_ptr    <= next_wr_ptr;
      rd_ptr    <= next_rd_ptr;
      count     <= next_count;
      out_valid <= next_out_valid;
      out_data  <= next_out_data;
    end
  end
endmodule

//--- logic/lts_logger.sv
// log record formatter: timestamp, delimiters, file split and oldest-file overwrite
// assumes the card store answers delete requests with a done pulse and reports usage in MB
// Operation
// - stamp detail level picks one of seven timestamp lengths, zero to six
// - level adds seconds, minutes, hours, day, month, year above milliseconds
// - nonzero clock delimiter goes between hour, minute and second digits
// - nonzero millis delimiter goes between seconds and milliseconds
// - nonzero calendar delimiter goes between year, month and day
// - nonzero calendar-clock delimiter goes between day and hour
// - clock, millis, calendar or calendar-clock delimiter code zero inserts nothing at that place
// - field delimiter code separates the fields of every record
// - logger name, up to 15 characters, heads every new file
// - default log state off means no records until an on control
// - file closes and a new one opens at split size, 1 to 512 MB
// - time split when seconds since midnight minus offset hits a multiple of the period
// - overwrite mode deletes oldest files before a new file opens when the card is full
// - overwrite mode with nonzero cap keeps stored data below the cap
`timescale 1ns/1ns
`include "lts_defs.svh"
module lts_logger
  import lts_pkg::*;
#(
  parameter int FIFO_DEPTH = `LTS_FIFO_DEPTH
) (
  input  wire logic                          mclk,                     // 125 MHz clock
  input  wire logic                          rstn,                     // async reset, low
  input  wire logic [2:0]                    stamp_detail_level,       // 0..6
  input  wire logic [7:0]                    clock_field_delimiter,    // 0 = none
  input  wire logic [7:0]                    millis_delimiter,         // 0 = none
  input  wire logic [7:0]                    calendar_delimiter,       // 0 = none
  input  wire logic [7:0]                    calendar_clock_delimiter, // 0 = none
  input  wire logic [7:0]                    field_delimiter_code,     // between fields
  input  wire logic [`LTS_NAME_LEN-1:0][7:0] logger_name_string,       // [0] first, 0 = unused
  input  wire logic                          default_log_state,        // state after reset
  input  wire logic [`LTS_SPLIT_MB_W-1:0]    split_size_limit,         // MB, 1..512
  input  wire logic [`LTS_SOD_W-1:0]         split_period,             // s, 0 = off
  input  wire logic [`LTS_SOD_W-1:0]         split_offset,             // s, below period
  input  wire logic                          overwrite_oldest_mode,    // delete oldest
  input  wire logic [`LTS_CAP_MB_W-1:0]      stored_total_cap,         // MB, 0 = card size
  input  wire logic                          ctrl_valid,               // control message
  input  wire logic [7:0]                    ctrl_state,               // control state byte
  input  wire lts_rtc_t                      rtc_now,                  // BCD wall time
  input  wire logic                          rtc_sec_tick,             // new second pulse
  input  wire logic [`LTS_SOD_W-1:0]         rtc_sec_of_day,           // s since midnight
  input  wire lts_beat_t                     rec_beat,                 // record character
  input  wire logic                          rec_valid,                // beat offered
  output logic                               rec_ready,                // beat taken
  input  wire logic                          card_full,                // store has no room
  input  wire logic [`LTS_CAP_MB_W-1:0]      card_used_mb,             // stored data, MB
  input  wire logic                          delete_done,              // oldest file gone
  output logic                               delete_oldest,            // delete request
  output logic                               file_open,                // new file pulse
  output logic                               file_close,               // close file pulse
  output logic                               logging_on,               // logging state
  output logic                               card_valid,               // character valid
  output logic [7:0]                         card_data,                // character
  input  wire logic                          card_ready                // store takes it
);
  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  generate
    if (FIFO_DEPTH < 4) begin : g_bad_depth
      $error("lts_logger needs a FIFO depth of at least 4");
    end
  endgenerate

  typedef struct packed {
    logic [`LTS_STAMP_MAX-1:0][7:0] chars;
    logic [4:0]                     len;
  } lts_stamp_t;

  // one pass over the 17 digits, most significant first, gated by detail level
  function automatic lts_stamp_t build_stamp(input lts_rtc_t t, input logic [2:0] lvl,
                                             input logic [7:0] cal, input logic [7:0] cc,
                                             input logic [7:0] clk_d, input logic [7:0] ms_d);
    lts_stamp_t s;
    logic [67:0] flat;
    logic [2:0]  need;
    logic [7:0]  dl;
    s    = '0;
    flat = t;
    for (int i = 0; i < `LTS_DIGITS; i++) begin
      need = (i < 4) ? 3'h6 : (i < 6) ? 3'h5 : (i < 8) ? 3'h4 :
             (i < 10) ? 3'h3 : (i < 12) ? 3'h2 : (i < 14) ? 3'h1 : 3'h0;
      if ((lvl > `LTS_LEVEL_MAX ? `LTS_LEVEL_MAX : lvl) >= need) begin
        s.chars[s.len] = `LTS_ASCII_ZERO | {4'h0, flat[67-4*i -: 4]};
        s.len          = s.len + 5'h1;
        dl = (i == 3 || i == 5) ? cal : (i == 7) ? cc :
             (i == 9 || i == 11) ? clk_d : (i == 13) ? ms_d : 8'h00;
        if (dl != 8'h00) begin
          s.chars[s.len] = dl;
          s.len          = s.len + 5'h1;
        end
      end
    end
    return s;
  endfunction

  lts_state_t                        state, next_state;
  lts_pend_t                         pend, next_pend;
  lts_stamp_t                        stamp, next_stamp;
  logic [4:0]                        idx, next_idx;
  logic                              started, next_started;
  logic                              next_logging_on;
  logic                              dropping, next_dropping;
  logic                              file_is_open, next_file_is_open;
  logic                              pend_time, next_pend_time;
  logic [`LTS_BYTES_W-1:0]           file_bytes, next_file_bytes;
  logic                              next_rec_ready, next_delete_oldest;
  logic                              next_file_open, next_file_close;
  logic                              wr_valid, wr_ready, fifo_idle;
  logic [7:0]                        wr_data;
  logic [LW-1:0]                     level;
  logic                              time_hit, size_hit, need_room, take;
  logic [`LTS_SOD_W-1:0]             since_off;
  logic [`LTS_BYTES_W-1:0]           limit_bytes;
  logic [`LTS_CAP_MB_W:0]            after_next;

  always_comb begin
    since_off   = rtc_sec_of_day - split_offset;
    // period of zero disables time split
    time_hit    = rtc_sec_tick && (split_period != '0) && (rtc_sec_of_day >= split_offset)
                  && ((since_off % split_period) == '0);
    limit_bytes = `LTS_BYTES_W'({split_size_limit, `LTS_MB_SHIFT'(0)});
    size_hit    = file_bytes >= limit_bytes;
    after_next  = {1'b0, card_used_mb} + (`LTS_CAP_MB_W+1)'(split_size_limit);
    // full card or cap would be reached by one more file
    need_room   = card_full || (overwrite_oldest_mode && (stored_total_cap != '0)
                  && (after_next >= {1'b0, stored_total_cap}));
    take        = rec_valid && rec_ready;
  end

  always_comb begin
    next_state         = state;
    next_pend          = pend;
    next_stamp         = stamp;
    next_idx           = idx;
    next_started       = 1'b1;
    next_logging_on    = logging_on;
    next_dropping      = dropping;
    next_file_is_open  = file_is_open;
    next_file_bytes    = file_bytes;
    next_delete_oldest = 1'b0;
    next_file_open     = 1'b0;
    next_file_close    = 1'b0;
    wr_valid           = 1'b0;
    wr_data            = 8'h00;
    // state after reset caught after release
    if (!started) begin
      next_logging_on = default_log_state;
    // on and off control bytes, others ignored
    end else if (ctrl_valid && ctrl_state == `LTS_CTRL_ON) begin
      next_logging_on = 1'b1;
    end else if (ctrl_valid && ctrl_state == `LTS_CTRL_OFF) begin
      next_logging_on = 1'b0;
    end
    // set wins over clear when a tick lands as a file closes
    next_pend_time = (pend_time && !(state == ST_CLOSE && fifo_idle) && state != ST_OPEN)
                     || time_hit;
    case (state)
      ST_IDLE: begin
        // records dropped whole while logging is off
        if (take) begin
          next_dropping = !rec_beat.rec_end;
        end else if (rec_valid && !dropping && logging_on && started) begin
          next_stamp = build_stamp(rtc_now, stamp_detail_level, calendar_delimiter,
                                   calendar_clock_delimiter, clock_field_delimiter,
                                   millis_delimiter);
          next_state = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (file_is_open && (size_hit || pend_time)) begin
          next_state = ST_CLOSE;
        end else if (file_is_open) begin
          next_idx   = 5'h0;
          next_state = ST_STAMP;
        // make room first; without overwrite wait for the store
        end else if (need_room) begin
          if (overwrite_oldest_mode) begin
            next_delete_oldest = 1'b1;
            next_state         = ST_DELETE;
          end
        end else begin
          next_state = ST_OPEN;
        end
      end
      ST_DELETE: begin
        if (delete_done) begin
          next_state = ST_CHECK;
        end
      end
      ST_CLOSE: begin
        // close only once queued characters reached the store
        if (fifo_idle) begin
          next_file_close   = 1'b1;
          next_file_is_open = 1'b0;
          next_state        = ST_CHECK;
        end
      end
      ST_OPEN: begin
        next_file_open    = 1'b1;
        next_file_is_open = 1'b1;
        next_file_bytes   = '0;
        next_idx          = 5'h0;
        next_state        = ST_HEADER;
      end
      ST_HEADER: begin
        // name characters, zero entries skipped, then newline
        if (idx == 5'(`LTS_NAME_LEN)) begin
          wr_valid = 1'b1;
          wr_data  = `LTS_ASCII_NL;
          if (wr_ready) begin
            next_idx   = 5'h0;
            next_state = ST_STAMP;
          end
        end else if (logger_name_string[idx[3:0]] == 8'h00) begin
          next_idx = idx + 5'h1;
        end else begin
          wr_valid = 1'b1;
          wr_data  = logger_name_string[idx[3:0]];
          if (wr_ready) begin
            next_idx = idx + 5'h1;
          end
        end
      end
      ST_STAMP: begin
        wr_valid = 1'b1;
        wr_data  = (idx == stamp.len) ? field_delimiter_code : stamp.chars[idx];
        if (wr_ready) begin
          next_idx = idx + 5'h1;
          if (idx == stamp.len) begin
            next_pend  = PEND_NONE;
            next_state = ST_BODY;
          end
        end
      end
      ST_BODY: begin
        if (pend != PEND_NONE) begin
          wr_valid = 1'b1;
          wr_data  = (pend == PEND_NL) ? `LTS_ASCII_NL : field_delimiter_code;
          if (wr_ready) begin
            next_pend = PEND_NONE;
            if (pend == PEND_NL) begin
              next_state = ST_IDLE;
            end
          end
        end else if (take) begin
          wr_valid  = 1'b1;
          wr_data   = rec_beat.data;
          next_pend = rec_beat.rec_end ? PEND_NL :
                      rec_beat.field_end ? PEND_DELIM : PEND_NONE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (wr_valid && wr_ready && state != ST_OPEN) begin
      next_file_bytes = next_file_bytes + `LTS_BYTES_W'(1);
    end
    // registered ready keeps a spare slot so a taken beat always fits
    next_rec_ready = (next_state == ST_BODY && next_pend == PEND_NONE
                      && level <= LW'(FIFO_DEPTH - 3))
                     || (next_state == ST_IDLE && started && (next_dropping || !next_logging_on));
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state         <= ST_IDLE;
      pend          <= PEND_NONE;
      stamp         <= '0;
      idx           <= 5'h0;
      started       <= 1'b0;
      logging_on    <= 1'b0;
      dropping      <= 1'b0;
      file_is_open  <= 1'b0;
      pend_time     <= 1'b0;
      file_bytes    <= '0;
      rec_ready     <= 1'b0;
      delete_oldest <= 1'b0;
      file_open     <= 1'b0;
      file_close    <= 1'b0;
    end else begin
      state         <= next_state;
      pend          <= next_pend;
      stamp         <= next_stamp;
      idx           <= next_idx;
      started       <= next_started;
      logging_on    <= next_logging_on;
      dropping      <= next_dropping;
      file_is_open  <= next_file_is_open;
      pend_time     <= next_pend_time;
      file_bytes    <= next_file_bytes;
      rec_ready     <= next_rec_ready;
      delete_oldest <= next_delete_oldest;
      file_open     <= next_file_open;
      file_close    <= next_file_close;
    end
  end

  lts_fifo #(
    .W (`LTS_CHAR_W),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rstn      (rstn),
    .in_valid  (wr_valid),
    .in_data   (wr_data),
    .in_ready  (wr_ready),
    .out_valid (card_valid),
    .out_data  (card_data),
    .out_ready (card_ready),
    .level     (level),
    .idle      (fifo_idle)
  );
endmodule

//--- logic/lts_pkg.sv
// types shared by the log timestamp and file split block
// assumes lts_defs.svh is on the include path
package lts_pkg;

  // real-time clock value, one BCD nibble per decimal digit
  typedef struct packed {
    logic [15:0] year;
    logic [7:0]  month;
    logic [7:0]  day;
    logic [7:0]  hour;
    logic [7:0]  minute;
    logic [7:0]  second;
    logic [11:0] milli;
  } lts_rtc_t;

  // one character of a record body with its boundary marks
  typedef struct packed {
    logic [7:0] data;
    logic       field_end;
    logic       rec_end;
  } lts_beat_t;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_CHECK  = 4'h1,
    ST_DELETE = 4'h2,
    ST_CLOSE  = 4'h3,
    ST_OPEN   = 4'h4,
    ST_HEADER = 4'h5,
    ST_STAMP  = 4'h6,
    ST_BODY   = 4'h7
  } lts_state_t;

  typedef enum logic [1:0] {
    PEND_NONE  = 2'h0,
    PEND_DELIM = 2'h1,
    PEND_NL    = 2'h2
  } lts_pend_t;

endpackage
